// *** include/ahic_cfg.svh ***
`ifndef AHIC_CFG_SVH
`define AHIC_CFG_SVH

`define AHIC_RESULT_W 12
`define AHIC_BUS_W 8
`define AHIC_NIB_W 4
`define AHIC_MSB_IDX 4'hb
`define AHIC_LAST_IDX 4'h0
`define AHIC_HIGH_LSB 8
`define AHIC_BIP_FLIP 12'h800
`define AHIC_RESULT_RST 12'h000
`define AHIC_STRB_LINE 5
`define AHIC_SCLK_LINE 6
`define AHIC_DOUT_LINE 7
`define AHIC_SER_OE_MASK 8'h1f
`define AHIC_BUS_ALL_OFF 8'hff
`define AHIC_BUS_ALL_ON 8'h00
`define AHIC_SYNC_W 6
`define AHIC_SYNC_RST 6'h18
`define AHIC_IN_CONV_CLK 5
`define AHIC_IN_CS 4
`define AHIC_IN_RD 3
`define AHIC_IN_HBS 2
`define AHIC_IN_POL 1
`define AHIC_IN_MODE 0

`endif

// *** include/ahic_pkg.sv ***
package ahic_pkg;

   typedef enum logic {AHIC_MODE_PARALLEL, AHIC_MODE_SERIAL} ahic_mode_t;

   typedef enum {AHIC_IDLE, AHIC_CONVERT} ahic_state_t;

   typedef logic [3:0] ahic_bit_idx_t;

endpackage : ahic_pkg

// *** rtl/ahic_conv_core.sv ***
`timescale 1ns/100ps
`include "ahic_cfg.svh"

module ahic_conv_core (
   input wire logic clk,
   input wire logic rstN,
   input wire logic startPulse,
   input wire logic convEdge,
   input wire logic polaritySelect,
   input wire logic [`AHIC_RESULT_W-1:0] analogCode,
   output logic busy,
   output ahic_pkg::ahic_bit_idx_t bitIdx,
   output logic decidedBit,
   output logic [`AHIC_RESULT_W-1:0] result
);

   ahic_pkg::ahic_state_t state_reg;
   ahic_pkg::ahic_state_t state_next;
   ahic_pkg::ahic_bit_idx_t idx_reg;
   ahic_pkg::ahic_bit_idx_t idx_next;
   logic [`AHIC_RESULT_W-1:0] held_reg;
   logic [`AHIC_RESULT_W-1:0] held_next;
   logic [`AHIC_RESULT_W-1:0] result_reg;
   logic [`AHIC_RESULT_W-1:0] result_next;

   always_comb begin
      state_next = state_reg;
      idx_next = idx_reg;
      held_next = held_reg;
      result_next = result_reg;
      case (state_reg)
         ahic_pkg::AHIC_IDLE: begin
            // starts during a conversion are dropped, the held sample stays
            if (startPulse) begin
               // offset binary becomes two's complement by flipping the msb
               held_next = polaritySelect ? (analogCode ^ `AHIC_BIP_FLIP) : analogCode;
               idx_next = `AHIC_MSB_IDX;
               state_next = ahic_pkg::AHIC_CONVERT;
            end
         end
         ahic_pkg::AHIC_CONVERT: begin
            if (convEdge) begin
               if (idx_reg == `AHIC_LAST_IDX) begin
                  // latch only at completion so byte reads stay stable
                  result_next = held_reg;
                  state_next = ahic_pkg::AHIC_IDLE;
               end else begin
                  idx_next = idx_reg - 4'h1;
               end
            end
         end
         default: begin
            state_next = ahic_pkg::AHIC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_reg <= ahic_pkg::AHIC_IDLE;
         idx_reg <= `AHIC_MSB_IDX;
         held_reg <= `AHIC_RESULT_RST;
         result_reg <= `AHIC_RESULT_RST;
      end else begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         held_reg <= held_next;
         result_reg <= result_next;
      end
   end

   assign busy = (state_reg == ahic_pkg::AHIC_CONVERT);
   assign bitIdx = idx_reg;
   assign decidedBit = held_reg[idx_reg];
   assign result = result_reg;

endmodule : ahic_conv_core

// *** rtl/ahic_host_if.sv ***
`timescale 1ns/100ps
`include "ahic_cfg.svh"

// Function
// - busy output low throughout each conversion, high again once result is ready.
// - parallel mode: read low with chip select and high-byte select low starts conversion.
// - parallel mode: data outputs driven only while read and chip select are low.
// - serial mode: serial clock and strobe outputs float whenever read is high.
// - serial mode: serial clock and strobe driven only with read and chip select low.
// - parallel mode: read and high-byte select ignored unless chip select is low.
// - serial mode: chip select falling edge starts a conversion.
// - serial mode: chip select high floats serial clock, strobe and data outputs.
// - parallel mode: high-byte select high puts four result msbs on low lines.
// - parallel mode: select low gives eight lsbs; select high blocks conversion starts.
// - serial mode, select low: serial clock toggles only during a conversion.
// - serial mode, select high with chip select low: serial clock runs continuously.
// - polarity select low gives unipolar coding, high gives bipolar coding.
// - twelve-bit result on shared three-state lines, bit 0 lsb, bit 11 msb.
// - serial mode reuses line 5 as strobe, 6 as clock, 7 as data.

module ahic_host_if (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic convClk,
   input wire logic chipSelect_b,
   input wire logic readStrobe_b,
   input wire logic high_byte_select,
   input wire logic polarity_select,
   input wire logic serialModeSel,
   input wire logic [`AHIC_RESULT_W-1:0] analogCode,
   output logic busy_b,
   output logic [`AHIC_BUS_W-1:0] dataOut,
   output logic [`AHIC_BUS_W-1:0] dataOe_b,
   output logic [`AHIC_RESULT_W-1:0] resultLatch
);

   // reset release, asserted asynchronously
   logic [1:0] rstSync_reg;
   logic rstN;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstSync_reg <= 2'h0;
      end else begin
         rstSync_reg <= {rstSync_reg[0], 1'b1};
      end
   end

   assign rstN = rstSync_reg[1];

   // every control pin input passes two flops before use; analogCode goes straight to the core
   logic [`AHIC_SYNC_W-1:0] rawIn;
   logic [`AHIC_SYNC_W-1:0] syncMeta_reg;
   logic [`AHIC_SYNC_W-1:0] syncIn_reg;

   assign rawIn[`AHIC_IN_CONV_CLK] = convClk;
   assign rawIn[`AHIC_IN_CS] = chipSelect_b;
   assign rawIn[`AHIC_IN_RD] = readStrobe_b;
   assign rawIn[`AHIC_IN_HBS] = high_byte_select;
   assign rawIn[`AHIC_IN_POL] = polarity_select;
   assign rawIn[`AHIC_IN_MODE] = serialModeSel;

   localparam logic [`AHIC_SYNC_W-1:0] SYNC_RST = `AHIC_SYNC_RST;

   genvar gi;
   generate
      for (gi = 0; gi < `AHIC_SYNC_W; gi = gi + 1) begin : gSync
         always_ff @(posedge clk or negedge rstN) begin
            if (!rstN) begin
               syncMeta_reg[gi] <= SYNC_RST[gi];
               syncIn_reg[gi] <= SYNC_RST[gi];
            end else begin
               syncMeta_reg[gi] <= rawIn[gi];
               syncIn_reg[gi] <= syncMeta_reg[gi];
            end
         end
      end
   endgenerate

   logic clkS;
   logic csLow;
   logic rdLow;
   logic hbs;
   logic pol;
   ahic_pkg::ahic_mode_t mode;

   assign clkS = syncIn_reg[`AHIC_IN_CONV_CLK];
   assign csLow = !syncIn_reg[`AHIC_IN_CS];
   assign rdLow = !syncIn_reg[`AHIC_IN_RD];
   assign hbs = syncIn_reg[`AHIC_IN_HBS];
   assign pol = syncIn_reg[`AHIC_IN_POL];
   // mode is expected static, so no glitch handling beyond the synchroniser
   assign mode = ahic_pkg::ahic_mode_t'(syncIn_reg[`AHIC_IN_MODE]);

   // edge history on synchronised copies only
   logic clkPrev_reg;
   logic clkPrev_next;
   logic csPrev_reg;
   logic csPrev_next;
   logic parReqPrev_reg;
   logic parReqPrev_next;

   logic parReq;
   logic convEdge;
   logic csFall;
   logic startPulse;

   always_comb begin
      clkPrev_next = clkS;
      csPrev_next = csLow;
      parReqPrev_next = parReq;
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         clkPrev_reg <= 1'b0;
         csPrev_reg <= 1'b0;
         parReqPrev_reg <= 1'b0;
      end else begin
         clkPrev_reg <= clkPrev_next;
         csPrev_reg <= csPrev_next;
         parReqPrev_reg <= parReqPrev_next;
      end
   end

   // read and select only count with chip select low
   // high-byte select high inhibits starts
   assign parReq = (mode == ahic_pkg::AHIC_MODE_PARALLEL) && csLow && rdLow && !hbs;
   assign convEdge = clkS && !clkPrev_reg;
   assign csFall = csLow && !csPrev_reg;

   always_comb begin
      startPulse = 1'b0;
      if (mode == ahic_pkg::AHIC_MODE_PARALLEL) begin
         // only the leading edge of the read request starts, so a long read
         // does not restart conversions back to back
         startPulse = parReq && !parReqPrev_reg;
      end else begin
         startPulse = csFall;
      end
   end

   logic busy;
   ahic_pkg::ahic_bit_idx_t bitIdx;
   logic decidedBit;
   logic [`AHIC_RESULT_W-1:0] result;

   ahic_conv_core uCore (
      .clk(clk),
      .rstN(rstN),
      .startPulse(startPulse),
      .convEdge(convEdge),
      .polaritySelect(pol),
      .analogCode(analogCode),
      .busy(busy),
      .bitIdx(bitIdx),
      .decidedBit(decidedBit),
      .result(result)
   );

   // output stage, all registered
   logic busyB_reg;
   logic busyB_next;
   logic [`AHIC_BUS_W-1:0] data_reg;
   logic [`AHIC_BUS_W-1:0] data_next;
   logic [`AHIC_BUS_W-1:0] oeB_reg;
   logic [`AHIC_BUS_W-1:0] oeB_next;

   logic sclkRun;
   logic sclkVal;
   logic strobeVal;
   logic serCtlOn;
   logic [`AHIC_BUS_W-1:0] parByte;

   // high byte is zero-extended onto the low lines
   assign parByte = hbs
      ? {{(`AHIC_BUS_W-`AHIC_NIB_W){1'b0}}, result[`AHIC_RESULT_W-1:`AHIC_HIGH_LSB]}
      : result[`AHIC_BUS_W-1:0];

   // continuous clock with select high and chip select low, else only while converting
   assign sclkRun = (hbs && csLow) || busy;
   assign sclkVal = sclkRun && clkS;
   // strobe marks the msb period of the serial word
   assign strobeVal = busy && (bitIdx == `AHIC_MSB_IDX);
   assign serCtlOn = csLow && rdLow;

   always_comb begin
      busyB_next = !busy;
      data_next = `AHIC_BUS_W'h00;
      oeB_next = `AHIC_BUS_ALL_OFF;
      if (mode == ahic_pkg::AHIC_MODE_PARALLEL) begin
         data_next = parByte;
         if (csLow && rdLow) begin
            oeB_next = `AHIC_BUS_ALL_ON;
         end
      end else begin
         data_next[`AHIC_STRB_LINE] = strobeVal;
         data_next[`AHIC_SCLK_LINE] = sclkVal;
         data_next[`AHIC_DOUT_LINE] = busy && decidedBit;
         oeB_next = `AHIC_BUS_ALL_OFF;
         if (serCtlOn) begin
            oeB_next[`AHIC_STRB_LINE] = 1'b0;
            oeB_next[`AHIC_SCLK_LINE] = 1'b0;
         end
         // chip select high floats all three serial lines
         if (csLow) begin
            oeB_next[`AHIC_DOUT_LINE] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         busyB_reg <= 1'b1;
         data_reg <= `AHIC_BUS_W'h00;
         oeB_reg <= `AHIC_BUS_ALL_OFF;
      end else begin
         busyB_reg <= busyB_next;
         data_reg <= data_next;
         oeB_reg <= oeB_next;
      end
   end

   assign busy_b = busyB_reg;
   assign dataOut = data_reg;
   assign dataOe_b = oeB_reg;
   assign resultLatch = result;

endmodule : ahic_host_if

// *** verif/ahic_host_model.sv ***
`timescale 1ns/100ps

module ahic_host_model (
   input wire logic run,
   output logic convClk
);
   // 160 ns period, offset so its edges never meet the system clock edges
   initial begin
      convClk = 1'b0;
      #3;
      forever begin
         #80;
         convClk = run ? ~convClk : 1'b0;
      end
   end
endmodule : ahic_host_model

// *** verif/ahic_host_if_monitor.sv ***
`timescale 1ns/100ps

module ahic_host_if_monitor (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic chipSelect_b,
   input wire logic readStrobe_b,
   input wire logic high_byte_select,
   input wire logic serialModeSel,
   input wire logic busy_b,
   input wire logic [7:0] dataOut,
   input wire logic [7:0] dataOe_b,
   input wire logic [11:0] resultLatch
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // five cycles covers the two-flop pin sync plus the output register
   sequence par_read(hb);
      (!serialModeSel && busy_b && !chipSelect_b && !readStrobe_b
       && high_byte_select == hb && $stable(resultLatch))[*5];
   endsequence
   par_off_a: assert property ((!serialModeSel && (readStrobe_b || chipSelect_b))[*4] |=> dataOe_b == 8'hff)
      else $error("bus driven without read and select");
   par_on_a: assert property ((!serialModeSel && !readStrobe_b && !chipSelect_b)[*4] |=> dataOe_b == 8'h00)
      else $error("bus not driven during read");
   low_byte_a: assert property (par_read(1'b0) |=> dataOut == resultLatch[7:0])
      else $error("low byte wrong");
   high_byte_a: assert property (par_read(1'b1) |=> dataOut == {4'h0, resultLatch[11:8]})
      else $error("high nibble wrong");
   start_block_a: assert property ((!serialModeSel && busy_b && (high_byte_select || chipSelect_b))[*5] |=> busy_b)
      else $error("conversion started while inhibited");
   ser_low_a: assert property (serialModeSel |-> dataOe_b[4:0] == 5'h1f)
      else $error("low lines driven in serial mode");
   ser_cs_a: assert property ((serialModeSel && chipSelect_b)[*4] |=> dataOe_b[7:5] == 3'h7)
      else $error("serial lines driven while deselected");
   ser_rd_a: assert property ((serialModeSel && readStrobe_b)[*4] |=> dataOe_b[6:5] == 2'h3)
      else $error("serial clock or strobe driven with read high");
   // the latch moves one cycle ahead of the registered busy output
   result_hold_a: assert property ($changed(resultLatch) |-> !busy_b ##1 busy_b)
      else $error("result changed outside completion");
endmodule : ahic_host_if_monitor

bind ahic_host_if ahic_host_if_monitor ahic_host_if_monitor_inst (.clk(clk), .rst_b(rst_b),
   .chipSelect_b(chipSelect_b), .readStrobe_b(readStrobe_b), .high_byte_select(high_byte_select),
   .serialModeSel(serialModeSel), .busy_b(busy_b), .dataOut(dataOut), .dataOe_b(dataOe_b),
   .resultLatch(resultLatch));

// *** verif/ahic_host_if_test.sv ***
`timescale 1ns/100ps
`define AHT_CHK(a, b) begin testsRun++; if ((a) !== (b)) begin failures++; $display("FAIL t=%0t got %h exp %h", $time, a, b); end end

module ahic_host_if_test;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic run = 1'b0;
   logic convClk;
   logic chipSelect_b = 1'b1;
   logic readStrobe_b = 1'b1;
   logic hbs = 1'b0;
   logic pol = 1'b0;
   logic ser = 1'b0;
   logic [11:0] code = 12'h000;
   logic busy_b;
   logic [7:0] dataOut;
   logic [7:0] dataOe_b;
   logic [11:0] resultLatch;
   logic [11:0] e;
   int failures = 0;
   int testsRun = 0;
   int cycles = 0;
   int n;
   always #5 clk = ~clk;
   ahic_host_model ahic_host_model_inst (.run(run), .convClk(convClk));
   ahic_host_if ahic_host_if_inst (.clk(clk), .rst_b(rst_b), .convClk(convClk),
      .chipSelect_b(chipSelect_b), .readStrobe_b(readStrobe_b), .high_byte_select(hbs),
      .polarity_select(pol), .serialModeSel(ser), .analogCode(code), .busy_b(busy_b),
      .dataOut(dataOut), .dataOe_b(dataOe_b), .resultLatch(resultLatch));
   function automatic logic [11:0] coded(logic [11:0] c, logic p);
      return p ? c ^ 12'h800 : c;
   endfunction : coded
   task automatic wrapUp();
      $display("comparisons %0d mismatches %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrapUp
   task automatic tick(int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick
   task automatic waitBusy(logic v);
      for (int i = 0; i < 600 && busy_b !== v; i++) tick(1);
      `AHT_CHK(busy_b, v)
   endtask : waitBusy
   task automatic reStart(logic s);
      @(posedge clk);
      rst_b <= 1'b0;
      ser <= s;
      tick(5);
      rst_b <= 1'b1;
      tick(5);
   endtask : reStart
   task automatic convert(logic [11:0] c, logic p);
      // serial starts need a fresh chip select falling edge
      setPins(1'b1, 1'b1, 1'b0, 4);
      @(posedge clk);
      code <= c;
      pol <= p;
      hbs <= 1'b0;
      chipSelect_b <= 1'b0;
      readStrobe_b <= 1'b0;
      run <= 1'b1;
      e = coded(c, p);
      waitBusy(1'b0);
      if (ser) `AHT_CHK({dataOe_b, dataOut[7], dataOut[5]}, {8'h1f, e[11], 1'b1})
      waitBusy(1'b1);
      run <= 1'b0;
      `AHT_CHK(resultLatch, e)
   endtask : convert
   task automatic setPins(logic cs, logic rd, logic hb, int k);
      @(posedge clk);
      chipSelect_b <= cs;
      readStrobe_b <= rd;
      hbs <= hb;
      tick(k);
   endtask : setPins
   task automatic parRead();
      tick(2);
      `AHT_CHK({dataOe_b, dataOut}, {8'h00, e[7:0]})
      setPins(1'b0, 1'b0, 1'b1, 20);
      `AHT_CHK({busy_b, dataOut}, {1'b1, 4'h0, e[11:8]})
      setPins(1'b1, 1'b0, 1'b0, 20);
      `AHT_CHK({busy_b, dataOe_b}, {1'b1, 8'hff})
      setPins(1'b1, 1'b1, 1'b0, 5);
      `AHT_CHK(resultLatch, e)
   endtask : parRead
   task automatic toggles(output int cnt);
      logic l;
      cnt = 0;
      l = dataOut[6];
      repeat (48) begin
         tick(1);
         if (dataOut[6] !== l) cnt++;
         l = dataOut[6];
      end
   endtask : toggles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         wrapUp();
      end
   end
   initial begin
      void'($urandom(78113));
      reStart(1'b0);
      convert(12'hfff, 1'b1);
      parRead();
      for (int i = 0; i < 6; i++) begin
         convert(12'($urandom), 1'($urandom));
         parRead();
      end
      reStart(1'b1);
      convert(12'h800, 1'b1);
      for (int i = 0; i < 4; i++) convert(12'($urandom), 1'($urandom));
      run <= 1'b1;
      toggles(n);
      `AHT_CHK(n, 0)
      setPins(1'b0, 1'b0, 1'b1, 1);
      toggles(n);
      `AHT_CHK(n > 0, 1'b1)
      setPins(1'b0, 1'b1, 1'b1, 5);
      `AHT_CHK(dataOe_b[6:5], 2'h3)
      waitBusy(1'b1);
      setPins(1'b1, 1'b1, 1'b0, 5);
      run <= 1'b0;
      `AHT_CHK(dataOe_b, 8'hff)
      wrapUp();
   end
endmodule : ahic_host_if_test
